// ==== src/lei_pkg.sv ====
// constants for the link event and interrupt register block
package lei_pkg;

  // ----------------------------------------------------------------
  // data width and event count
  // ----------------------------------------------------------------
  localparam int unsigned LEI_DW      = 8;
  localparam int unsigned LEI_NUM_EVT = 7;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] LEI_ADDR_RSVD51 = 8'h51;
  localparam logic [7:0] LEI_ADDR_BOOST  = 8'h52;
  localparam logic [7:0] LEI_ADDR_RSVD53 = 8'h53;
  localparam logic [7:0] LEI_ADDR_STATUS = 8'h54;
  localparam logic [7:0] LEI_ADDR_RSVD55 = 8'h55;
  localparam logic [7:0] LEI_ADDR_ENABLE = 8'h56;

  // ----------------------------------------------------------------
  // reset and fixed read values
  // ----------------------------------------------------------------
  localparam logic [7:0] LEI_BOOST_RST  = 8'h00;
  localparam logic [7:0] LEI_STATUS_RST = 8'h00;
  localparam logic [7:0] LEI_ENABLE_RST = 8'h00;
  localparam logic [7:0] LEI_RSVD_VAL   = 8'h00;
  localparam logic [7:0] LEI_RSVD55_VAL = 8'h02;
  localparam logic [7:0] LEI_UNMAP_VAL  = 8'h00;

  // ----------------------------------------------------------------
  // status and enable bit positions
  // ----------------------------------------------------------------
  localparam int unsigned LEI_BIT_CARRIER    = 7;
  localparam int unsigned LEI_BIT_LOCK_FOUND = 6;
  localparam int unsigned LEI_BIT_SEC_FOUND  = 5;
  localparam int unsigned LEI_BIT_PRI_FOUND  = 4;
  localparam int unsigned LEI_BIT_EYE_MET    = 3;
  localparam int unsigned LEI_BIT_LOCK_LOST  = 2;
  localparam int unsigned LEI_BIT_SEC_LOST   = 1;
  localparam int unsigned LEI_BIT_PRI_LOST   = 0;

  // ----------------------------------------------------------------
  // start-up states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LEI_ST_PRIME = 2'b01,
    LEI_ST_RUN   = 2'b10
  } lei_state_e;

endpackage

// ==== src/lei_evt_if.sv ====
// event set, clear and flag signals between the register block and its latch bank
`timescale 1ns/1ns
interface lei_evt_if;
  import lei_pkg::*;
  logic [LEI_NUM_EVT-1:0] set;
  logic [LEI_NUM_EVT-1:0] clr;
  logic [LEI_NUM_EVT-1:0] flag;

  modport latch_mp (
    input  set,
    input  clr,
    output flag
  );
  modport ctrl_mp (
    output set,
    output clr,
    input  flag
  );
endinterface

// ==== src/lei_event_latch.sv ====
// bank of sticky event flags, set dominant over clear
`timescale 1ns/1ns
module lei_event_latch
  import lei_pkg::*;
(
  input  wire logic   core_clk_i,
  input  wire logic   rst_n_i,
  lei_evt_if.latch_mp evt
);

  // ----------------------------------------------------------------
  // one flag per event
  // ----------------------------------------------------------------
  logic [LEI_NUM_EVT-1:0] flag_q;

  for (genvar i = 0; i < LEI_NUM_EVT; i++) begin : g_flag
    always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
        flag_q[i] <= LEI_STATUS_RST[i];
      end else if (evt.set[i]) begin
        // a new event beats a read-clear in the same cycle
        flag_q[i] <= 1'b1;
      end else if (evt.clr[i]) begin
        flag_q[i] <= 1'b0;
      end
    end
  end

  assign evt.flag = flag_q;

endmodule

// ==== src/lei_link_event_regs.sv ====
// event status, event enable and boost readback registers of the link front end
`timescale 1ns/1ns
// ------------------------------------------------------------------
// Contract
// - read-only boost readback of adapted_boost_value_i
// - status bit 7 shows live selected carrier
// - bit 6 sets on lock gained
// - bit 5 sets on secondary carrier found
// - bit 4 sets on primary carrier found
// - bit 3 sets on eye thresholds reached
// - bit 2 sets on lock lost
// - bit 1 sets on secondary carrier lost
// - bit 0 sets on primary carrier lost
// - status read clears it, resets zero
// - enable bit 6 gates lock gained
// - enable bit 5 gates secondary found
// - enable bit 4 gates primary found
// - enable bit 3 gates eye threshold
// - enable bit 2 gates lock lost
// - enable bit 1 gates secondary lost
// - enable bit 0 gates primary lost, reset zero
// ------------------------------------------------------------------
module lei_link_event_regs
  import lei_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic              rst_n_i,
  input  wire logic [7:0]        reg_addr_i,
  input  wire logic              reg_rd_i,
  input  wire logic              reg_wr_i,
  input  wire logic [LEI_DW-1:0] reg_wdata_i,
  output logic      [LEI_DW-1:0] reg_rdata_o,
  output logic                   reg_rvalid_o,
  input  wire logic              primary_carrier_i,
  input  wire logic              secondary_carrier_i,
  input  wire logic              input_select_i,
  input  wire logic              cdr_lock_i,
  input  wire logic              eye_threshold_met_i,
  input  wire logic [LEI_DW-1:0] adapted_boost_value_i,
  output logic                   irq_o
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  lei_state_e             state_q;
  logic                   primed;
  logic                   pri_prev_q;
  logic                   sec_prev_q;
  logic                   lock_prev_q;
  logic                   eye_prev_q;
  logic                   primary_signal_found_event;
  logic                   secondary_signal_found_event;
  logic                   primary_signal_lost_event;
  logic                   secondary_signal_lost_event;
  logic                   lock_found_event;
  logic                   lock_lost_event;
  logic                   eye_met_event;
  logic                   live_carrier;
  logic                   status_rd;
  logic                   enable_wr;
  logic [LEI_DW-1:0]      boost_q;
  logic [LEI_DW-1:0]      enable_q;
  logic [LEI_DW-1:0]      status_word;
  logic [LEI_DW-1:0]      rdata_d;
  logic [LEI_DW-1:0]      rdata_q;
  logic                   rvalid_q;
  logic                   irq_q;
  logic [LEI_NUM_EVT-1:0] set_vec;

  lei_evt_if evt ();

  lei_event_latch u_latch (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .evt        (evt.latch_mp)
  );

  // ----------------------------------------------------------------
  // start-up: first cycle after release only loads history
  // ----------------------------------------------------------------
  // without this, a carrier already present at release would be
  // reported as a fresh event
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state_q <= LEI_ST_PRIME;
    end else begin
      unique case (state_q)
        LEI_ST_PRIME: state_q <= LEI_ST_RUN;
        LEI_ST_RUN:   state_q <= LEI_ST_RUN;
        default:      state_q <= LEI_ST_PRIME;
      endcase
    end
  end

  assign primed = (state_q == LEI_ST_RUN);

  // ----------------------------------------------------------------
  // condition history for edge detection
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pri_prev_q  <= 1'b0;
      sec_prev_q  <= 1'b0;
      lock_prev_q <= 1'b0;
      eye_prev_q  <= 1'b0;
    end else begin
      pri_prev_q  <= primary_carrier_i;
      sec_prev_q  <= secondary_carrier_i;
      lock_prev_q <= cdr_lock_i;
      eye_prev_q  <= eye_threshold_met_i;
    end
  end

  // ----------------------------------------------------------------
  // event edges
  // ----------------------------------------------------------------
  assign lock_found_event             = primed & cdr_lock_i & ~lock_prev_q;
  assign secondary_signal_found_event = primed & secondary_carrier_i & ~sec_prev_q;
  assign primary_signal_found_event   = primed & primary_carrier_i & ~pri_prev_q;
  assign eye_met_event                = primed & eye_threshold_met_i & ~eye_prev_q;
  assign lock_lost_event              = primed & ~cdr_lock_i & lock_prev_q;
  assign secondary_signal_lost_event  = primed & ~secondary_carrier_i & sec_prev_q;
  assign primary_signal_lost_event    = primed & ~primary_carrier_i & pri_prev_q;

  always_comb begin
    set_vec                     = '0;
    set_vec[LEI_BIT_LOCK_FOUND] = lock_found_event;
    set_vec[LEI_BIT_SEC_FOUND]  = secondary_signal_found_event;
    set_vec[LEI_BIT_PRI_FOUND]  = primary_signal_found_event;
    set_vec[LEI_BIT_EYE_MET]    = eye_met_event;
    set_vec[LEI_BIT_LOCK_LOST]  = lock_lost_event;
    set_vec[LEI_BIT_SEC_LOST]   = secondary_signal_lost_event;
    set_vec[LEI_BIT_PRI_LOST]   = primary_signal_lost_event;
  end

  assign evt.set = set_vec;

  // ----------------------------------------------------------------
  // register access decode
  // ----------------------------------------------------------------
  assign status_rd = reg_rd_i && (reg_addr_i == LEI_ADDR_STATUS);
  assign enable_wr = reg_wr_i && (reg_addr_i == LEI_ADDR_ENABLE);
  assign evt.clr   = {LEI_NUM_EVT{status_rd}};

  // ----------------------------------------------------------------
  // boost readback capture
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      boost_q <= LEI_BOOST_RST;
    end else begin
      boost_q <= adapted_boost_value_i;
    end
  end

  // ----------------------------------------------------------------
  // enable register
  // ----------------------------------------------------------------
  // bit 7 is kept and read back but gates nothing
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      enable_q <= LEI_ENABLE_RST;
    end else if (enable_wr) begin
      enable_q <= reg_wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  assign live_carrier = input_select_i ? secondary_carrier_i : primary_carrier_i;
  assign status_word  = {live_carrier, evt.flag};

  always_comb begin
    rdata_d = LEI_UNMAP_VAL;
    unique case (reg_addr_i)
      LEI_ADDR_BOOST:  rdata_d = boost_q;
      LEI_ADDR_STATUS: rdata_d = status_word;
      LEI_ADDR_ENABLE: rdata_d = enable_q;
      LEI_ADDR_RSVD51: rdata_d = LEI_RSVD_VAL;
      LEI_ADDR_RSVD53: rdata_d = LEI_RSVD_VAL;
      LEI_ADDR_RSVD55: rdata_d = LEI_RSVD55_VAL;
      default:         rdata_d = LEI_UNMAP_VAL;
    endcase
  end

  // read data holds until the next read
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rdata_q  <= LEI_UNMAP_VAL;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_rd_i;
      if (reg_rd_i) begin
        rdata_q <= rdata_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt indication
  // ----------------------------------------------------------------
  // enables gate only the output; flags latch regardless so software
  // polling sees every event
  // each enable bit 0 to 6 gates its own flag only
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(evt.flag & enable_q[LEI_NUM_EVT-1:0]);
    end
  end

  assign reg_rdata_o  = rdata_q;
  assign reg_rvalid_o = rvalid_q;
  assign irq_o        = irq_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  property p_boost_readback;
    ($past(rst_n_i) && reg_rd_i && (reg_addr_i == LEI_ADDR_BOOST)) ##1 rst_n_i |->
      reg_rvalid_o && (reg_rdata_o == $past(adapted_boost_value_i, 2));
  endproperty
  a_boost_readback: assert property (p_boost_readback) else $error("boost readback wrong");

  property p_live_carrier;
    status_rd |=> reg_rdata_o[LEI_BIT_CARRIER] == $past(live_carrier);
  endproperty
  a_live_carrier: assert property (p_live_carrier) else $error("carrier bit not live");

  property p_lock_found;
    primed && $rose(cdr_lock_i) |=> evt.flag[LEI_BIT_LOCK_FOUND];
  endproperty
  a_lock_found: assert property (p_lock_found) else $error("lock gained not latched");

  property p_sec_found;
    primed && $rose(secondary_carrier_i) |=> evt.flag[LEI_BIT_SEC_FOUND];
  endproperty
  a_sec_found: assert property (p_sec_found) else $error("secondary found not latched");

  property p_pri_found;
    primed && $rose(primary_carrier_i) |=> evt.flag[LEI_BIT_PRI_FOUND];
  endproperty
  a_pri_found: assert property (p_pri_found) else $error("primary found not latched");

  property p_eye_met;
    primed && $rose(eye_threshold_met_i) |=> evt.flag[LEI_BIT_EYE_MET];
  endproperty
  a_eye_met: assert property (p_eye_met) else $error("eye threshold not latched");

  property p_lock_lost;
    primed && $fell(cdr_lock_i) |=> evt.flag[LEI_BIT_LOCK_LOST];
  endproperty
  a_lock_lost: assert property (p_lock_lost) else $error("lock loss not latched");

  property p_sec_lost;
    primed && $fell(secondary_carrier_i) |=> evt.flag[LEI_BIT_SEC_LOST];
  endproperty
  a_sec_lost: assert property (p_sec_lost) else $error("secondary loss not latched");

  property p_pri_lost;
    primed && $fell(primary_carrier_i) |=> evt.flag[LEI_BIT_PRI_LOST];
  endproperty
  a_pri_lost: assert property (p_pri_lost) else $error("primary loss not latched");

  property p_read_clear;
    status_rd && !(|set_vec) |=> (evt.flag == '0) && (reg_rdata_o[LEI_NUM_EVT-1:0] == $past(evt.flag));
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("status read did not clear");

  property p_en_lock_found;
    evt.flag[LEI_BIT_LOCK_FOUND] && enable_q[LEI_BIT_LOCK_FOUND] |=> irq_o;
  endproperty
  a_en_lock_found: assert property (p_en_lock_found) else $error("lock gained irq missing");

  property p_en_sec_found;
    evt.flag[LEI_BIT_SEC_FOUND] && enable_q[LEI_BIT_SEC_FOUND] |=> irq_o;
  endproperty
  a_en_sec_found: assert property (p_en_sec_found) else $error("secondary found irq missing");

  property p_en_pri_found;
    evt.flag[LEI_BIT_PRI_FOUND] && enable_q[LEI_BIT_PRI_FOUND] |=> irq_o;
  endproperty
  a_en_pri_found: assert property (p_en_pri_found) else $error("primary found irq missing");

  property p_en_eye_met;
    evt.flag[LEI_BIT_EYE_MET] && enable_q[LEI_BIT_EYE_MET] |=> irq_o;
  endproperty
  a_en_eye_met: assert property (p_en_eye_met) else $error("eye threshold irq missing");

  property p_en_lock_lost;
    evt.flag[LEI_BIT_LOCK_LOST] && enable_q[LEI_BIT_LOCK_LOST] |=> irq_o;
  endproperty
  a_en_lock_lost: assert property (p_en_lock_lost) else $error("lock loss irq missing");

  property p_en_sec_lost;
    evt.flag[LEI_BIT_SEC_LOST] && enable_q[LEI_BIT_SEC_LOST] |=> irq_o;
  endproperty
  a_en_sec_lost: assert property (p_en_sec_lost) else $error("secondary loss irq missing");

  property p_en_pri_lost;
    evt.flag[LEI_BIT_PRI_LOST] && enable_q[LEI_BIT_PRI_LOST] |=> irq_o;
  endproperty
  a_en_pri_lost: assert property (p_en_pri_lost) else $error("primary loss irq missing");

  property p_flag_hold;
    (|evt.flag) && !status_rd |=> (evt.flag & $past(evt.flag)) == $past(evt.flag);
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without read");

  property p_irq_off;
    ((evt.flag & enable_q[LEI_NUM_EVT-1:0]) == '0) |=> !irq_o;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq without enabled flag");

  property p_enable_write;
    enable_wr ##1 (reg_rd_i && (reg_addr_i == LEI_ADDR_ENABLE) && !enable_wr) |=>
      reg_rdata_o == $past(reg_wdata_i, 2);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable write not read back");

  property p_set_wins;
    status_rd |=> (evt.flag & $past(set_vec)) == $past(set_vec);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost to a status read");

  property p_status_ro;
    reg_wr_i && (reg_addr_i == LEI_ADDR_STATUS) && !status_rd && !(|set_vec) |=> evt.flag == $past(evt.flag);
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status changed by a write");

endmodule

// ==== src/lei_unused_placeholder_never.sv ====
// intentionally empty file kept out
`timescale 1ns/1ns

// ==== dv/lei_host_model.sv ====
// host model driving the register strobe port of the event block
`timescale 1ns/1ns
module lei_host_model
  import lei_pkg::*;
(
  input  wire logic              core_clk_i,
  output logic      [7:0]        reg_addr_o,
  output logic                   reg_rd_o,
  output logic                   reg_wr_o,
  output logic      [LEI_DW-1:0] reg_wdata_o,
  input  wire logic [LEI_DW-1:0] reg_rdata_i,
  input  wire logic              reg_rvalid_i
);
  initial begin
    reg_addr_o  = 8'h00;
    reg_rd_o    = 1'b0;
    reg_wr_o    = 1'b0;
    reg_wdata_o = 8'h00;
  end

  // ----------------------------------------------------------------
  // write: one strobe cycle, no answer comes back
  // ----------------------------------------------------------------
  // two writes can run back to back, as the next call raises the strobe again after it drops at the taking edge
  task automatic wr_reg(input logic [7:0] a, input logic [LEI_DW-1:0] d);
    reg_addr_o  <= a;
    reg_wdata_o <= d;
    reg_wr_o    <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_o    <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // read: strobe one cycle, then wait a bounded time for the answer
  // ----------------------------------------------------------------
  task automatic rd_reg(input logic [7:0] a, output logic [LEI_DW-1:0] d, output int lat);
    reg_addr_o <= a;
    reg_rd_o   <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_o   <= 1'b0;
    // stale address is inverted so a late sample never looks like the request
    reg_addr_o <= ~a;
    lat = 0;
    d   = 'x;
    repeat (4) begin
      @(posedge core_clk_i);
      lat++;
      if (reg_rvalid_i === 1'b1) begin
        d = reg_rdata_i;
        break;
      end
    end
  endtask
endmodule

// ==== dv/test_link_event_interrupt_regs.sv ====
// self-checking bench for the link event and interrupt register block
`timescale 1ns/1ns
`define CHK(nm, e, g) \
  begin \
    num_checks++; \
    if ((g) !== (e)) begin \
      failures++; \
      $display("unexpected %s exp %h got %h", nm, e, g); \
    end \
  end
module test_link_event_interrupt_regs
  import lei_pkg::*;
;
  logic              clk;
  logic              rst_n;
  logic [7:0]        addr;
  logic              rd;
  logic              wr;
  logic [LEI_DW-1:0] wdata;
  logic [LEI_DW-1:0] rdata;
  logic              rvalid;
  logic              sel;
  logic [3:0]        lv;
  logic [LEI_DW-1:0] boost;
  logic              irq;
  logic [6:0]        exp_flags;
  logic [7:0]        exp_en;
  int                failures;
  int                num_checks;

  always #25 clk = ~clk;

  // lv packs {lock, eye, secondary carrier, primary carrier}
  lei_link_event_regs u_lei_link_event_regs (
    .core_clk_i           (clk),
    .rst_n_i              (rst_n),
    .reg_addr_i           (addr),
    .reg_rd_i             (rd),
    .reg_wr_i             (wr),
    .reg_wdata_i          (wdata),
    .reg_rdata_o          (rdata),
    .reg_rvalid_o         (rvalid),
    .primary_carrier_i    (lv[0]),
    .secondary_carrier_i  (lv[1]),
    .input_select_i       (sel),
    .cdr_lock_i           (lv[3]),
    .eye_threshold_met_i  (lv[2]),
    .adapted_boost_value_i(boost),
    .irq_o                (irq)
  );

  lei_host_model u_lei_host_model (
    .core_clk_i  (clk),
    .reg_addr_o  (addr),
    .reg_rd_o    (rd),
    .reg_wr_o    (wr),
    .reg_wdata_o (wdata),
    .reg_rdata_i (rdata),
    .reg_rvalid_i(rvalid)
  );

  // ----------------------------------------------------------------
  // expectation helpers
  // ----------------------------------------------------------------
  // eye falling gives no event, so only its rise is mapped
  function automatic logic [6:0] events(input logic [3:0] o, input logic [3:0] n);
    logic [3:0] r;
    logic [3:0] f;
    r = n & ~o;
    f = o & ~n;
    return {r[3], r[1], r[0], r[2], f[3], f[1], f[0]};
  endfunction

  task automatic results();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string nm);
    logic [LEI_DW-1:0] d;
    int                lat;
    u_lei_host_model.rd_reg(a, d, lat);
    `CHK("read latency", 1, lat);
    `CHK(nm, e, d);
    if (lat > 1) begin
      results();
    end
  endtask

  task automatic wr_en(input logic [7:0] d);
    u_lei_host_model.wr_reg(LEI_ADDR_ENABLE, d);
    exp_en = d;
  endtask

  task automatic apply(input logic [3:0] n, input logic s);
    lv    <= n;
    sel   <= s;
    boost <= 8'($urandom);
    exp_flags = exp_flags | events(lv, n);
    repeat (4) @(posedge clk);
    `CHK("irq", |(exp_flags & exp_en[6:0]), irq);
  endtask

  task automatic rd_status();
    logic [7:0] exp_st;
    exp_st = {(sel ? lv[1] : lv[0]), exp_flags};
    rd_chk(LEI_ADDR_STATUS, exp_st, "status");
    exp_flags = '0;
    @(posedge clk);
    `CHK("irq after clear", 1'b0, irq);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h9ba6704c));
    clk       = 1'b0;
    rst_n     = 1'b0;
    sel       = 1'b0;
    lv        = 4'h0;
    boost     = 8'($urandom);
    exp_flags = '0;
    exp_en    = '0;
    failures  = 0;
    num_checks = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK("irq at reset", 1'b0, irq);
    rd_chk(LEI_ADDR_STATUS, LEI_STATUS_RST, "status reset");
    rd_chk(LEI_ADDR_ENABLE, LEI_ENABLE_RST, "enable reset");
    rd_chk(LEI_ADDR_RSVD51, LEI_RSVD_VAL, "rsvd51");
    rd_chk(LEI_ADDR_RSVD53, LEI_RSVD_VAL, "rsvd53");
    rd_chk(LEI_ADDR_RSVD55, LEI_RSVD55_VAL, "rsvd55");
    rd_chk(8'h60, LEI_UNMAP_VAL, "unmapped");
    // writes to read-only places must leave them untouched
    u_lei_host_model.wr_reg(LEI_ADDR_BOOST, 8'hff);
    @(posedge clk);
    u_lei_host_model.wr_reg(LEI_ADDR_STATUS, 8'hff);
    rd_chk(LEI_ADDR_BOOST, boost, "boost");
    rd_status();
    // write then read in the very next cycle
    wr_en(8'($urandom));
    rd_chk(LEI_ADDR_ENABLE, exp_en, "enable");
    for (int i = 0; i < 120; i++) begin
      if ($urandom_range(2) == 0) begin
        wr_en(8'($urandom));
      end
      apply(4'($urandom), 1'($urandom));
      if ($urandom_range(1) == 0) begin
        rd_status();
      end
      if (i % 8 == 0) begin
        rd_chk(LEI_ADDR_BOOST, boost, "boost");
        rd_chk(LEI_ADDR_ENABLE, exp_en, "enable");
      end
    end
    // back-to-back status reads: the second shows only the live carrier
    apply(4'hf, 1'b1);
    rd_status();
    rd_status();
    // edges at the very clearing read: set wins, so they wait for the next read
    exp_flags = events(lv, 4'h0);
    lv <= 4'h0;
    rd_chk(LEI_ADDR_STATUS, 8'h00, "status at clear");
    rd_status();
    // reset in mid-run with a carrier already present: no event at release
    apply(4'b0001, 1'b0);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    exp_flags = '0;
    exp_en    = '0;
    repeat (3) @(posedge clk);
    `CHK("irq after reset", 1'b0, irq);
    rd_status();
    rd_chk(LEI_ADDR_ENABLE, LEI_ENABLE_RST, "enable after reset");
    results();
  end
endmodule
